// ==== src/mjh_pkg.sv ====
// Package with constants and carrier types for the motion job handshake
package mjh_pkg;
    // Axis status word layout
    localparam int STW_WIDTH = 32;
    localparam int STW_ENABLE_BIT = 0;
    localparam int STW_HOMED_BIT = 5;
    localparam int STW_OPEN_LOOP_BIT = 28;
    // Error cause codes
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_TECH_ALARM = 16'h8001;
    localparam logic [15:0] ERR_NOT_ENABLED = 16'h8101;
    localparam logic [15:0] ERR_ALARM_PENDING = 16'h8102;
    localparam logic [15:0] ERR_NOT_HOMED = 16'h8103;
    // Reset values
    localparam logic RST_OPEN_LOOP = 1'b1;

    typedef enum logic [1:0] {
        MJH_MOVE_ABS,
        MJH_MOVE_REL,
        MJH_HOME,
        MJH_OTHER
    } mjh_kind_e;

    // Axis condition from the outside world
    typedef struct packed {
        logic enabled;
        logic homed;
        logic [15:0] pending_alarm_number;
        logic [15:0] alarm_reaction_code;
    } mjh_axis_s;

    // Job result flags
    typedef struct packed {
        logic busy;
        logic done;
        logic aborted;
        logic error;
    } mjh_flags_s;
endpackage

// ==== src/mjh_edge_detect.sv ====
// Rising edge detector for the job trigger
`timescale 1ns/1ps
module mjh_edge_detect (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic level_in,
    output logic rise_out
);
    logic prev_q;

    // Previous level; reset to high so a trigger held through reset is no edge
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_out = level_in & ~prev_q;
endmodule

// ==== src/mjh_precheck.sv ====
// Precondition check for a new motion job
`timescale 1ns/1ps
module mjh_precheck (
    input mjh_pkg::mjh_axis_s axis_in,
    input mjh_pkg::mjh_kind_e kind_in,
    output logic ok_out,
    output logic [15:0] cause_out
);
    import mjh_pkg::*;

    // Priority: enable first, then alarms, then homing for absolute moves
    always_comb begin
        ok_out = 1'b1;
        cause_out = ERR_NONE;
        if (!axis_in.enabled) begin
            ok_out = 1'b0;
            cause_out = ERR_NOT_ENABLED;
        end else if (axis_in.pending_alarm_number != 16'h0000 ||
                     axis_in.alarm_reaction_code != 16'h0000) begin
            ok_out = 1'b0;
            cause_out = ERR_ALARM_PENDING;
        end else if (kind_in == MJH_MOVE_ABS && !axis_in.homed) begin
            ok_out = 1'b0;
            cause_out = ERR_NOT_HOMED;
        end
    end
endmodule

// ==== src/mjh_motion_job_handshake.sv ====
// Job handshake and status tracker for one motion command with completion
// Summary of operation
// - A job starts only on a rising edge of the trigger.
// - Busy is high while an accepted job executes.
// - Normal finish drops busy and raises done in the same cycle.
// - Done only when no error and no interruption by a later job.
// - Interruption by another job clears busy and raises aborted.
// - A fault while running clears busy and raises error.
// - A final flag stays high while the trigger stays high.
// - Trigger low at completion gives done for one cycle.
// - Trigger low at interruption gives aborted for one cycle.
// - Trigger low at fault gives error for one cycle.
// - All status outputs refresh every clock cycle.
// - Jobs accepted only while axis enable bit 0 is true.
// - Jobs need pending alarm number and reaction code both zero.
// - Absolute moves need the homed bit 5 true.
// - A fault sets error, rejects the job, shows a cause code.
// - Cause 16'h8001 with error means a technology alarm occurred.
// - Open loop operation shows as status word bit 28.
// - Absolute or relative moves force closed loop, which then stays until an open loop request.
`timescale 1ns/1ps
module mjh_motion_job_handshake (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic job_trigger_in,
    input mjh_pkg::mjh_kind_e job_kind_in,
    input mjh_pkg::mjh_axis_s axis_in,
    input wire logic target_reached_in,
    input wire logic job_interrupt_in,
    input wire logic tech_alarm_in,
    input wire logic open_loop_request_in,
    input wire logic closed_loop_request_in,
    output mjh_pkg::mjh_flags_s flags_out,
    output logic job_busy_out,
    output logic job_done_out,
    output logic job_aborted_flag_out,
    output logic job_error_out,
    output logic [15:0] error_cause_code_out,
    output logic [mjh_pkg::STW_WIDTH-1:0] axis_status_word_out,
    output logic job_start_out
);
    import mjh_pkg::*;

    typedef enum logic [2:0] {
        MJH_IDLE,
        MJH_RUN,
        MJH_SHOW_DONE,
        MJH_SHOW_ABORT,
        MJH_SHOW_ERROR
    } mjh_state_e;

    mjh_state_e state_q;
    mjh_state_e state_d;
    mjh_flags_s flags_q;
    mjh_flags_s flags_d;
    logic [15:0] cause_q;
    logic [15:0] cause_d;
    logic open_loop_q;
    logic trig_rise;
    logic pre_ok;
    logic [15:0] pre_cause;

    // Trigger edge detection
    mjh_edge_detect u_edge (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(job_trigger_in),
        .rise_out(trig_rise)
    );

    // Axis precondition check
    mjh_precheck u_pre (
        .axis_in(axis_in),
        .kind_in(job_kind_in),
        .ok_out(pre_ok),
        .cause_out(pre_cause)
    );

    // Flags after a final event: shown from the next cycle regardless of trigger level
    function automatic mjh_flags_s final_flags(input logic d, input logic a,
                                               input logic e);
        mjh_flags_s f;
        f.busy = 1'b0;
        f.done = d;
        f.aborted = a;
        f.error = e;
        return f;
    endfunction

    // Job sequencing; a final flag is shown at least one cycle and then held
    // only while the trigger stays high
    always_comb begin
        state_d = state_q;
        flags_d = flags_q;
        cause_d = cause_q;
        case (state_q)
            MJH_IDLE, MJH_SHOW_DONE, MJH_SHOW_ABORT, MJH_SHOW_ERROR: begin
                if (state_q != MJH_IDLE && !job_trigger_in) begin
                    state_d = MJH_IDLE;
                    flags_d = final_flags(1'b0, 1'b0, 1'b0);
                    cause_d = ERR_NONE;
                end
                if (trig_rise) begin
                    if (pre_ok) begin
                        state_d = MJH_RUN;
                        flags_d = final_flags(1'b0, 1'b0, 1'b0);
                        flags_d.busy = 1'b1;
                        cause_d = ERR_NONE;
                    end else begin
                        // Rejected job: error with cause, no retry
                        state_d = MJH_SHOW_ERROR;
                        flags_d = final_flags(1'b0, 1'b0, 1'b1);
                        cause_d = pre_cause;
                    end
                end
            end
            MJH_RUN: begin
                // Abort and fault outrank completion in the same cycle
                if (job_interrupt_in) begin
                    state_d = MJH_SHOW_ABORT;
                    flags_d = final_flags(1'b0, 1'b1, 1'b0);
                end else if (tech_alarm_in) begin
                    state_d = MJH_SHOW_ERROR;
                    flags_d = final_flags(1'b0, 1'b0, 1'b1);
                    cause_d = ERR_TECH_ALARM;
                end else if (target_reached_in) begin
                    state_d = MJH_SHOW_DONE;
                    flags_d = final_flags(1'b1, 1'b0, 1'b0);
                end
            end
            default: begin
                state_d = MJH_IDLE;
                flags_d = final_flags(1'b0, 1'b0, 1'b0);
                cause_d = ERR_NONE;
            end
        endcase
    end

    // State and flag registers, refreshed every cycle
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= MJH_IDLE;
            flags_q <= '0;
            cause_q <= ERR_NONE;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            cause_q <= cause_d;
        end
    end

    // Position control mode; moves force closed loop and it then persists until an open loop request
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            open_loop_q <= RST_OPEN_LOOP;
        end else if (state_q != MJH_RUN && state_d == MJH_RUN &&
                     (job_kind_in == MJH_MOVE_ABS ||
                      job_kind_in == MJH_MOVE_REL)) begin
            open_loop_q <= 1'b0;
        end else if (closed_loop_request_in) begin
            open_loop_q <= 1'b0;
        end else if (open_loop_request_in) begin
            open_loop_q <= 1'b1;
        end
    end

    // Outputs straight from flip-flops
    assign flags_out = flags_q;
    assign job_busy_out = flags_q.busy;
    assign job_done_out = flags_q.done;
    assign job_aborted_flag_out = flags_q.aborted;
    assign job_error_out = flags_q.error;
    assign error_cause_code_out = cause_q;
    // Start strobe is a handshake output, combinational by choice
    assign job_start_out = (state_q != MJH_RUN) && (state_d == MJH_RUN);

    // Status word mirrors axis condition plus our loop mode
    always_comb begin
        axis_status_word_out = '0;
        axis_status_word_out[STW_ENABLE_BIT] = axis_in.enabled;
        axis_status_word_out[STW_HOMED_BIT] = axis_in.homed;
        axis_status_word_out[STW_OPEN_LOOP_BIT] = open_loop_q;
    end

    // Checks beside the logic
    sequence run_s;
        state_q == MJH_RUN;
    endsequence

    sequence interrupted_s;
        run_s ##0 job_interrupt_in;
    endsequence

    busy_on_accept_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        trig_rise && pre_ok && state_q != MJH_RUN |=> flags_q.busy)
        else $error("busy not raised on accepted job");

    done_with_drop_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        run_s ##0 target_reached_in && !job_interrupt_in && !tech_alarm_in
        |=> flags_q.done && !flags_q.busy)
        else $error("done and busy not swapped together");

    abort_flag_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        interrupted_s |=> flags_q.aborted && !flags_q.busy && !flags_q.done)
        else $error("abort not reported");

    fault_flag_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        run_s ##0 tech_alarm_in && !job_interrupt_in
        |=> flags_q.error && cause_q == ERR_TECH_ALARM)
        else $error("technology alarm cause missing");

    hold_while_high_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        (flags_q.done || flags_q.aborted || flags_q.error) && job_trigger_in
        && !trig_rise |=> $stable(flags_q))
        else $error("final flag dropped while trigger high");

    one_cycle_low_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        $rose(flags_q.done) && !job_trigger_in && !trig_rise
        |=> !flags_q.done)
        else $error("done held longer than one cycle");

    reject_idle_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        trig_rise && !axis_in.enabled && state_q != MJH_RUN
        |=> !flags_q.busy && flags_q.error)
        else $error("job accepted on disabled axis");

    no_start_level_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        state_q != MJH_RUN && !trig_rise |=> state_q != MJH_RUN)
        else $error("job started without edge");

    closed_loop_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        job_start_out && job_kind_in == MJH_MOVE_REL
        |=> !axis_status_word_out[STW_OPEN_LOOP_BIT])
        else $error("move left axis open loop");

    // Steps shared by the checks below
    sequence accept_s;
        trig_rise && pre_ok && state_q != MJH_RUN;
    endsequence

    sequence refuse_s;
        trig_rise && state_q != MJH_RUN && axis_in.enabled;
    endsequence

    // Flag first seen with the caller already gone; a new edge is excluded
    sequence shown_low_s(flag);
        $rose(flag) && !job_trigger_in && !trig_rise;
    endsequence

    busy_in_run_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        run_s |-> flags_q.busy && !flags_q.done)
        else $error("busy missing while running");

    fault_drops_busy_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        run_s ##0 tech_alarm_in && !job_interrupt_in
        |=> !flags_q.busy && flags_q.error && !flags_q.aborted)
        else $error("fault did not end the job");

    error_wins_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        run_s ##0 target_reached_in && (tech_alarm_in || job_interrupt_in)
        |=> !flags_q.done)
        else $error("done shown after a failed job");

    done_clean_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        flags_q.done |-> !flags_q.aborted && !flags_q.error && !flags_q.busy)
        else $error("done shown beside another flag");

    abort_one_cycle_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        shown_low_s(flags_q.aborted) |=> !flags_q.aborted)
        else $error("aborted held longer than one cycle");

    error_one_cycle_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        shown_low_s(flags_q.error) |=> !flags_q.error)
        else $error("error held longer than one cycle");

    alarm_refusal_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        refuse_s ##0 (axis_in.pending_alarm_number != 16'h0000 ||
                      axis_in.alarm_reaction_code != 16'h0000)
        |=> flags_q.error && !flags_q.busy && cause_q == ERR_ALARM_PENDING)
        else $error("job accepted with an alarm pending");

    homing_refusal_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        refuse_s ##0 job_kind_in == MJH_MOVE_ABS && !axis_in.homed
        && axis_in.pending_alarm_number == 16'h0000
        && axis_in.alarm_reaction_code == 16'h0000
        |=> flags_q.error && !flags_q.busy && cause_q == ERR_NOT_HOMED)
        else $error("absolute move accepted before homing");

    cause_present_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        flags_q.error |-> cause_q != ERR_NONE && !flags_q.busy)
        else $error("error shown without a cause");

    accept_clears_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        accept_s |=> flags_q.busy && !flags_q.done
        && !flags_q.aborted && !flags_q.error && cause_q == ERR_NONE)
        else $error("old result left on a new job");

    release_clears_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        (flags_q.done || flags_q.aborted || flags_q.error) && !job_trigger_in
        |=> !flags_q.done && !flags_q.aborted && !flags_q.error)
        else $error("final flag kept after trigger fell");

    loop_persist_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        !open_loop_q && !open_loop_request_in |=> !open_loop_q)
        else $error("closed loop lost without a request");

    abs_closed_loop_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        job_start_out && job_kind_in == MJH_MOVE_ABS
        |=> !axis_status_word_out[STW_OPEN_LOOP_BIT])
        else $error("absolute move left axis open loop");

    open_loop_shown_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        open_loop_request_in && !closed_loop_request_in && !job_start_out
        |=> axis_status_word_out[STW_OPEN_LOOP_BIT])
        else $error("open loop not shown in status word");

    status_pins_a: assert property (@(posedge clk_sys_in)
        disable iff (reset_in)
        {job_busy_out, job_done_out, job_aborted_flag_out, job_error_out}
        == flags_out && error_cause_code_out == cause_q)
        else $error("status pins disagree with flag struct");
endmodule

// ==== verif/mjh_caller_model.sv ====
// Model of the calling program that drives the job trigger
`timescale 1ns/1ps
module mjh_caller_model (
    input wire logic clk_sys_in,
    output logic trigger_out
);
    initial trigger_out = 1'b0;

    // New job: a fresh low-to-high step, low for one sampled edge first
    task automatic launch();
        if (trigger_out) begin
            trigger_out = 1'b0;
            @(negedge clk_sys_in);
        end
        trigger_out = 1'b1;
    endtask

    // Release the trigger; called just after a falling edge
    task automatic drop();
        trigger_out = 1'b0;
    endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the motion job handshake
`timescale 1ns/1ps
module testbench;
    import mjh_pkg::*;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic trig, reached = 0, intr = 0, alarm = 0, olr = 0, clr = 0;
    mjh_kind_e kind = MJH_MOVE_ABS;
    mjh_axis_s axis = '{1'b1, 1'b1, 16'h0000, 16'h0000};
    mjh_flags_s flags;
    logic busy, done, abrt, err, start;
    logic [15:0] cause;
    logic [STW_WIDTH-1:0] stw;
    int bad_count = 0;
    int comparisons = 0;

    // Half period of the 40 MHz clock
    always #12.5 clk_sys_in = ~clk_sys_in;

    mjh_caller_model u_caller (.clk_sys_in(clk_sys_in), .trigger_out(trig));

    mjh_motion_job_handshake u_dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .job_trigger_in(trig), .job_kind_in(kind), .axis_in(axis),
        .target_reached_in(reached), .job_interrupt_in(intr),
        .tech_alarm_in(alarm), .open_loop_request_in(olr),
        .closed_loop_request_in(clr), .flags_out(flags),
        .job_busy_out(busy), .job_done_out(done),
        .job_aborted_flag_out(abrt), .job_error_out(err),
        .error_cause_code_out(cause), .axis_status_word_out(stw),
        .job_start_out(start)
    );

    task automatic check(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    // Flags as {busy, done, aborted, error}, struct and single pins alike
    task automatic fl(input logic [3:0] exp);
        check({28'h0, flags}, {28'h0, exp}, "flag struct");
        check(32'({busy, done, abrt, err}), 32'(exp), "pins");
    endtask

    // Inputs move only just after the falling edge
    task automatic step();
        @(negedge clk_sys_in);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Pulse one end event for a cycle: 0 completion, 1 alarm, 2 interrupt
    task automatic finish_with(input int which);
        {intr, alarm, reached} = 3'b001 << which;
        step();
        {intr, alarm, reached} = 3'b000;
    endtask

    task automatic t_done_hold();
        u_caller.launch();
        #1 check(start, 1'b1, "start pulse");
        step();
        fl(4'b1000);
        check(stw[STW_OPEN_LOOP_BIT], 1'b0, "closed loop");
        step();
        check(start, 1'b0, "no restart on held high");
        finish_with(0);
        fl(4'b0100);
        repeat (3) step();
        fl(4'b0100);
        u_caller.drop();
        step();
        fl(4'b0000);
        check(stw[STW_OPEN_LOOP_BIT], 1'b0, "loop mode kept");
        $display("test done_hold finished");
    endtask

    // Trigger low before the end event; the flag lasts one cycle
    task automatic t_pulse(input int which, input logic [3:0] exp);
        kind = MJH_MOVE_REL;
        u_caller.launch();
        step();
        u_caller.drop();
        step();
        fl(4'b1000);
        // Completion raised beside the alarm or interrupt too; that end event must win
        {intr, alarm, reached} = (3'b001 << which) | 3'b001;
        step();
        {intr, alarm, reached} = 3'b000;
        fl(exp);
        step();
        fl(4'b0000);
        $display("test pulse %0d finished", which);
    endtask

    task automatic t_alarm_restart();
        u_caller.launch();
        step();
        finish_with(1);
        fl(4'b0001);
        check(cause, ERR_TECH_ALARM, "alarm cause");
        step();
        fl(4'b0001);
        u_caller.launch();
        step();
        fl(4'b1000);
        // Trigger let go, then a new edge while done is still shown
        u_caller.drop();
        finish_with(0);
        fl(4'b0100);
        u_caller.launch();
        step();
        fl(4'b1000);
        finish_with(0);
        fl(4'b0100);
        u_caller.drop();
        step();
        fl(4'b0000);
        $display("test alarm_restart finished");
    endtask

    task automatic t_precheck();
        mjh_axis_s cfg[5];
        mjh_kind_e kd[5];
        logic [15:0] ec[5];
        cfg = '{'{0, 1, 0, 0}, '{1, 1, 7, 0}, '{1, 1, 0, 3},
                '{1, 0, 0, 0}, '{1, 0, 0, 0}};
        kd = '{MJH_MOVE_ABS, MJH_MOVE_REL, MJH_MOVE_ABS, MJH_MOVE_ABS,
               MJH_HOME};
        ec = '{ERR_NOT_ENABLED, ERR_ALARM_PENDING, ERR_ALARM_PENDING,
               ERR_NOT_HOMED, ERR_NONE};
        for (int i = 0; i < 5; i++) begin
            axis = cfg[i];
            kind = kd[i];
            u_caller.launch();
            step();
            check(stw[STW_ENABLE_BIT], cfg[i].enabled, "enable");
            check(stw[STW_HOMED_BIT], cfg[i].homed, "homed bit");
            fl(i < 4 ? 4'b0001 : 4'b1000);
            if (i < 4) check(cause, ec[i], "refusal cause");
            if (i == 4) finish_with(0);
            u_caller.drop();
            step();
            fl(4'b0000);
        end
        axis = '{1'b1, 1'b1, 16'h0000, 16'h0000};
        olr = 1'b1;
        step();
        olr = 1'b0;
        check(stw[STW_OPEN_LOOP_BIT], 1'b1, "open loop shown");
        clr = 1'b1;
        step();
        clr = 1'b0;
        check(stw[STW_OPEN_LOOP_BIT], 1'b0, "closed loop again");
        $display("test precheck finished");
    endtask

    initial begin
        repeat (8) step();
        reset_in = 1'b0;
        step();
        fl(4'b0000);
        check(stw[STW_OPEN_LOOP_BIT], RST_OPEN_LOOP, "init loop");
        check(cause, ERR_NONE, "reset cause");
        t_done_hold();
        t_pulse(0, 4'b0100);
        t_pulse(1, 4'b0001);
        t_pulse(2, 4'b0010);
        t_alarm_restart();
        t_precheck();
        test_done();
    end

    // Whole run is about fifty cycles; allow ample margin
    initial begin
        repeat (2000) @(posedge clk_sys_in);
        bad_count++;
        test_done();
    end
endmodule
